// file: src/nand_host.sv
// Host-side sequencer driving command, address and data cycles of a flash
`timescale 1ns/1ps
`default_nettype none
module nand_host
  import nand_host_pkg::*;
  (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmdValid,
    input wire op_t cmdOp,
    input wire logic [COL_W-1:0] cmdCol,
    input wire logic [ROW_W-1:0] cmdRow,
    input wire logic [LEN_W-1:0] cmdLen,
    output logic cmdReady,
    output logic cmdDone,
    output logic cmdErr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic wrValid,
    output logic wrReady,
    output logic [DATA_W-1:0] rdData,
    output logic rdValid,
    input wire logic rdReady,
    output logic [DATA_W-1:0] statusByte,
    output logic opFail,
    output logic ceN,
    output logic cle,
    output logic ale,
    output logic weN,
    output logic reN,
    output logic [DATA_W-1:0] dqOut,
    output logic dqOe,
    input wire logic [DATA_W-1:0] dqIn,
    input wire logic rbReady
  );

  typedef enum {ST_IDLE, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_BUSY,
    ST_DOUT} state_t;

  state_t state_r;
  logic ph_r;
  logic [7:0] code1_r;
  logic [7:0] code2_r;
  logic sendC1_r;
  logic sendC2_r;
  logic [2:0] nAddr_r;
  logic [2:0] addrIdx_r;
  logic [LEN_W-1:0] inLen_r;
  logic [LEN_W-1:0] outLen_r;
  logic [LEN_W-1:0] cnt_r;
  logic waitRb_r;
  logic thenStatus_r;
  logic toStatus_r;
  logic [3:0] wbCnt_r;
  logic [COL_W-1:0] col_r;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] srcRow_r;
  logic [ROW_W-1:0] progRow_r;
  logic [3:0] progCnt_r;
  logic readMode_r;
  logic cacheMode_r;
  logic dataLoaded_r;
  logic pushValid_r;
  logic [DATA_W-1:0] pushData_r;
  logic fifoInReady;
  logic refuse;

  // Address byte order: two column cycles, then three row cycles
  function automatic logic [7:0] addrByte(input logic [2:0] idx,
    input logic [COL_W-1:0] c, input logic [ROW_W-1:0] r);
    case (idx)
      3'h0: addrByte = c[7:0];
      3'h1: addrByte = {4'h0, c[11:8]};
      3'h2: addrByte = r[7:0];
      3'h3: addrByte = r[15:8];
      default: addrByte = r[23:16];
    endcase
  endfunction

  // Which step follows once the earlier steps are done
  function automatic state_t stepAfter(input logic [1:0] from);
    if (from < 2'h1 && nAddr_r != '0)
      stepAfter = ST_ADDR;
    else if (from < 2'h2 && inLen_r != '0)
      stepAfter = ST_DIN;
    else if (from < 2'h3 && sendC2_r)
      stepAfter = ST_CMD2;
    else if (waitRb_r)
      stepAfter = ST_BUSY;
    else if (outLen_r != '0)
      stepAfter = ST_DOUT;
    else
      stepAfter = ST_IDLE;
  endfunction

  // ==========================================================
  // Refusal of sequences the device would misbehave on
  always_comb
  begin
    refuse = 1'b0;
    case (cmdOp)
      OP_RAND_OUT: refuse = cacheMode_r;                          // [R6]
      OP_PROG_GO: refuse = !dataLoaded_r ||                        // [R14]
        (progRow_r == row_r && progCnt_r == MAX_PARTIAL_PROGS);    // [R12]
      OP_COPY_PROG: refuse =
        (cmdRow[PAGE_PARITY_BIT] != srcRow_r[PAGE_PARITY_BIT]) ||  // [R20]
        (cmdRow[DIE_BIT] != srcRow_r[DIE_BIT]);                    // [R20]
      OP_PROG_LOAD, OP_RAND_IN: refuse = (cmdLen == '0) ||         // [R11]
        (cmdLen > PAGE_BYTES);
      default: refuse = 1'b0;
    endcase
  end

  // ==========================================================
  // Sequencer and pins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      ph_r <= 1'b0;
      code1_r <= CODE_READ;
      code2_r <= CODE_READ_GO;
      sendC1_r <= 1'b0;
      sendC2_r <= 1'b0;
      nAddr_r <= '0;
      addrIdx_r <= '0;
      inLen_r <= '0;
      outLen_r <= '0;
      cnt_r <= '0;
      waitRb_r <= 1'b0;
      thenStatus_r <= 1'b0;
      toStatus_r <= 1'b0;
      wbCnt_r <= '0;
      col_r <= '0;
      row_r <= '0;
      srcRow_r <= '0;
      progRow_r <= '0;
      progCnt_r <= '0;
      readMode_r <= 1'b1;                                          // [R1]
      cacheMode_r <= 1'b0;
      dataLoaded_r <= 1'b0;
      pushValid_r <= 1'b0;
      pushData_r <= '0;
      cmdReady <= 1'b0;
      cmdDone <= 1'b0;
      cmdErr <= 1'b0;
      wrReady <= 1'b0;
      statusByte <= '0;
      opFail <= 1'b0;
      ceN <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      weN <= 1'b1;
      reN <= 1'b1;
      dqOut <= '0;
      dqOe <= 1'b0;
    end
    else if (ce)
    begin
      cmdDone <= 1'b0;
      cmdErr <= 1'b0;
      pushValid_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          cle <= 1'b0;
          ale <= 1'b0;
          dqOe <= 1'b0;
          ceN <= 1'b0;
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady)
          begin
            cmdReady <= 1'b0;
            if (refuse)
            begin
              cmdErr <= 1'b1;
            end
            else
            begin
              state_r <= ST_CMD1;
              ph_r <= 1'b0;
              addrIdx_r <= '0;
              col_r <= cmdCol;
              row_r <= cmdRow;
              sendC1_r <= 1'b1;
              sendC2_r <= 1'b0;
              nAddr_r <= '0;
              inLen_r <= '0;
              outLen_r <= '0;
              waitRb_r <= 1'b0;
              thenStatus_r <= 1'b0;
              toStatus_r <= 1'b0;
              case (cmdOp)
                OP_READ, OP_CACHE_READ:
                begin
                  code1_r <= CODE_READ;
                  sendC1_r <= !readMode_r;                         // [R2]
                  nAddr_r <= FULL_ADDR_CYCLES;
                  sendC2_r <= 1'b1;
                  waitRb_r <= 1'b1;                                // [R3] [R26]
                  outLen_r <= cmdLen;                              // [R4]
                  readMode_r <= 1'b1;
                  if (cmdOp == OP_CACHE_READ)
                  begin
                    code2_r <= CODE_CACHE_GO;                      // [R7]
                    col_r <= '0;                                   // [R7]
                    cacheMode_r <= 1'b1;                           // [R8]
                  end
                  else
                  begin
                    code2_r <= CODE_READ_GO;
                    cacheMode_r <= 1'b0;
                  end
                end
                OP_CACHE_EXIT:
                begin
                  code1_r <= CODE_CACHE_EXIT;                      // [R10] [R25]
                  waitRb_r <= 1'b1;
                  outLen_r <= cmdLen;
                  cacheMode_r <= 1'b0;
                end
                OP_RAND_OUT:
                begin
                  code1_r <= CODE_RAND_OUT;                        // [R5]
                  code2_r <= CODE_RAND_OUT_GO;
                  nAddr_r <= COL_ADDR_CYCLES;
                  sendC2_r <= 1'b1;
                  outLen_r <= cmdLen;
                end
                OP_PROG_LOAD:
                begin
                  code1_r <= CODE_PROG;                            // [R14]
                  nAddr_r <= FULL_ADDR_CYCLES;
                  inLen_r <= cmdLen;                               // [R11] [R13]
                  readMode_r <= 1'b0;
                  cacheMode_r <= 1'b0;
                  dataLoaded_r <= 1'b0;
                end
                OP_RAND_IN:
                begin
                  code1_r <= CODE_RAND_IN;                         // [R15]
                  nAddr_r <= COL_ADDR_CYCLES;
                  inLen_r <= cmdLen;
                  row_r <= row_r;
                end
                OP_PROG_GO:
                begin
                  code1_r <= CODE_PROG_GO;
                  row_r <= row_r;
                  waitRb_r <= 1'b1;                                // [R16] [R26]
                  thenStatus_r <= 1'b1;                            // [R18]
                  dataLoaded_r <= 1'b0;
                  progRow_r <= row_r;
                  progCnt_r <= (progRow_r == row_r) ?
                    progCnt_r + 1'b1 : 4'h1;                       // [R12]
                end
                OP_COPY_READ:
                begin
                  code1_r <= CODE_READ;                            // [R19]
                  code2_r <= CODE_COPY_GO;
                  nAddr_r <= COPY_ADDR_CYCLES;
                  sendC2_r <= 1'b1;
                  waitRb_r <= 1'b1;
                  srcRow_r <= cmdRow;
                  readMode_r <= 1'b0;
                  cacheMode_r <= 1'b0;
                end
                OP_COPY_PROG:
                begin
                  code1_r <= CODE_RAND_IN; // [R19] [R22] repeated copy-back of the same data is not limited
                  code2_r <= CODE_PROG_GO;
                  nAddr_r <= COPY_ADDR_CYCLES;
                  sendC2_r <= 1'b1;
                  waitRb_r <= 1'b1;
                  thenStatus_r <= 1'b1;                            // [R21]
                end
                OP_STATUS:
                begin
                  code1_r <= CODE_STATUS;                          // [R9]
                  outLen_r <= 12'h001;
                  toStatus_r <= 1'b1;
                  readMode_r <= 1'b0;
                end
                default:
                begin
                  code1_r <= CODE_RESET;
                  waitRb_r <= 1'b1;
                  readMode_r <= 1'b1;
                  cacheMode_r <= 1'b0;
                  dataLoaded_r <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_CMD1:
        begin
          if (!sendC1_r)
          begin
            state_r <= stepAfter(2'h0);
          end
          else if (!ph_r)
          begin
            cle <= 1'b1;                                           // [R23]
            ale <= 1'b0;
            weN <= 1'b0;
            dqOut <= code1_r;
            dqOe <= 1'b1;
            ph_r <= 1'b1;
          end
          else
          begin
            weN <= 1'b1;
            ph_r <= 1'b0;
            cnt_r <= inLen_r;
            state_r <= stepAfter(2'h0);
          end
        end
        ST_ADDR:
        begin
          if (!ph_r)
          begin
            cle <= 1'b0;
            ale <= 1'b1;
            weN <= 1'b0;
            dqOut <= addrByte(addrIdx_r, col_r, row_r);            // [R24]
            dqOe <= 1'b1;
            ph_r <= 1'b1;
          end
          else
          begin
            weN <= 1'b1;
            ph_r <= 1'b0;
            addrIdx_r <= addrIdx_r + 1'b1;
            cnt_r <= inLen_r;
            if (addrIdx_r + 1'b1 == nAddr_r)
            begin
              state_r <= stepAfter(2'h1);
            end
          end
        end
        ST_DIN:
        begin
          if (!ph_r)
          begin
            cle <= 1'b0;
            ale <= 1'b0;
            if (wrValid && wrReady)
            begin
              wrReady <= 1'b0;
              weN <= 1'b0;
              dqOut <= wrData;
              dqOe <= 1'b1;
              ph_r <= 1'b1;
            end
            else
            begin
              wrReady <= 1'b1;
            end
          end
          else
          begin
            weN <= 1'b1;
            ph_r <= 1'b0;
            dataLoaded_r <= 1'b1;
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == 12'h001)
            begin
              state_r <= stepAfter(2'h2);
            end
          end
        end
        ST_CMD2:
        begin
          if (!ph_r)
          begin
            cle <= 1'b1;
            ale <= 1'b0;
            weN <= 1'b0;
            dqOut <= code2_r;
            dqOe <= 1'b1;
            ph_r <= 1'b1;
          end
          else
          begin
            weN <= 1'b1;
            ph_r <= 1'b0;
            state_r <= stepAfter(2'h3);
          end
        end
        ST_BUSY:
        begin
          cle <= 1'b0;
          dqOe <= 1'b0;
          // Ready/busy lags the strobe; sampling at once would see stale high
          if (wbCnt_r != BUSY_START_CYC)
          begin
            wbCnt_r <= wbCnt_r + 1'b1;
          end
          else if (rbReady)                                        // [R26]
          begin
            wbCnt_r <= '0;
            cnt_r <= outLen_r;
            if (thenStatus_r)
            begin
              // Fetch the outcome so errors are never missed
              code1_r <= CODE_STATUS;                              // [R17] [R21]
              sendC1_r <= 1'b1;
              nAddr_r <= '0;
              inLen_r <= '0;
              sendC2_r <= 1'b0;
              waitRb_r <= 1'b0;
              outLen_r <= 12'h001;
              toStatus_r <= 1'b1;
              thenStatus_r <= 1'b0;
              state_r <= ST_CMD1;
            end
            else
            begin
              state_r <= (outLen_r != '0) ? ST_DOUT : ST_IDLE;
            end
          end
        end
        ST_DOUT:
        begin
          dqOe <= 1'b0;
          cle <= 1'b0;
          ale <= 1'b0;
          if (!ph_r)
          begin
            if (cnt_r == '0)
            begin
              cnt_r <= outLen_r;
            end
            // A push still in flight is not yet in the buffer's count
            else if ((fifoInReady && !pushValid_r) || toStatus_r)
            begin
              reN <= 1'b0;
              ph_r <= 1'b1;
            end
          end
          else
          begin
            reN <= 1'b1;
            ph_r <= 1'b0;
            cnt_r <= cnt_r - 1'b1;
            if (toStatus_r)
            begin
              statusByte <= dqIn;                                  // [R9]
              opFail <= dqIn[STATUS_FAIL_BIT];                     // [R17]
            end
            else
            begin
              pushValid_r <= 1'b1;                                 // [R4]
              pushData_r <= dqIn;
            end
            if (cnt_r == 12'h001)
            begin
              state_r <= ST_IDLE;
              outLen_r <= '0;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
      if ((state_r == ST_DOUT && ph_r && cnt_r == 12'h001) ||
        (state_r == ST_BUSY && wbCnt_r == BUSY_START_CYC && rbReady &&
        !thenStatus_r && outLen_r == '0) ||
        (ph_r && ((state_r == ST_CMD2 && stepAfter(2'h3) == ST_IDLE) ||
        (state_r == ST_DIN && cnt_r == 12'h001 &&
        stepAfter(2'h2) == ST_IDLE))))
      begin
        cmdDone <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read data buffer; a full buffer holds off read pulses
  nand_read_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) readBuf (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .inData(pushData_r),
    .inValid(pushValid_r),
    .inReady(fifoInReady),
    .outData(rdData),
    .outValid(rdValid),
    .outReady(rdReady)
  );

endmodule
`default_nettype wire

// file: src/nand_host_pkg.sv
// Constants and types shared by the flash host sequencer
// What the device document requires
// R1 - Device powers up in read mode
// R2 - Back-to-back reads skip setup, send 30h only
// R3 - Each read first moves page, busy low
// R4 - Each read pulse gives next column
// R5 - Random output reloads column within page
// R6 - No random output during cache read
// R7 - Cache read: setup, address, confirm, column 00h
// R8 - Cache read busy only for latency
// R9 - Status flags show controller and cache readiness
// R10 - Exit cache read outputs page n only
// R11 - Partial program of 1 to 2112 bytes
// R12 - At most eight partial programs per page
// R13 - Sequential input addresses stay in one block
// R14 - Program: setup, address, data, confirm; data required
// R15 - Random input: setup plus two column cycles
// R16 - While programming only status and reset act
// R17 - Program error flags only failed 1-to-0 cells
// R18 - Program done: ready flag, status mode held
// R19 - Copy-back: source read, then target program
// R20 - Copy-back keeps page parity and die bit
// R21 - Copy-back failure shows in status error
// R22 - Limit repeated copy-back of same data; the host keeps no copy-back count
// R23 - Commands on lower data lanes, rising strobe
// R24 - Extra address cycles ignored by device
// R25 - Exit cache read accepted during cache busy
// R26 - Wait ready or status after each confirm
package nand_host_pkg;

  typedef enum logic [3:0] {
    OP_READ, OP_CACHE_READ, OP_CACHE_EXIT, OP_RAND_OUT, OP_PROG_LOAD,
    OP_RAND_IN, OP_PROG_GO, OP_COPY_READ, OP_COPY_PROG, OP_STATUS, OP_RESET
  } op_t;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CODE_READ = 8'h00;
  localparam logic [7:0] CODE_READ_GO = 8'h30;
  localparam logic [7:0] CODE_CACHE_GO = 8'h31;
  localparam logic [7:0] CODE_CACHE_EXIT = 8'h34;
  localparam logic [7:0] CODE_COPY_GO = 8'h35;
  localparam logic [7:0] CODE_RAND_OUT = 8'h05;
  localparam logic [7:0] CODE_RAND_OUT_GO = 8'hE0;
  localparam logic [7:0] CODE_PROG = 8'h80;
  localparam logic [7:0] CODE_RAND_IN = 8'h85;
  localparam logic [7:0] CODE_PROG_GO = 8'h10;
  localparam logic [7:0] CODE_STATUS = 8'h70;
  localparam logic [7:0] CODE_RESET = 8'hFF;

  // ==========================================================
  // Geometry and fields
  localparam int DATA_W = 8;
  localparam int COL_W = 12;
  localparam int ROW_W = 24;
  localparam int LEN_W = 12;
  localparam logic [LEN_W-1:0] PAGE_BYTES = 12'h840;
  localparam logic [2:0] FULL_ADDR_CYCLES = 3'h5;
  localparam logic [2:0] COPY_ADDR_CYCLES = 3'h4;
  localparam logic [2:0] COL_ADDR_CYCLES = 3'h2;
  localparam int PAGE_PARITY_BIT = 0;
  localparam int DIE_BIT = 16;
  localparam logic [3:0] MAX_PARTIAL_PROGS = 4'h8;
  localparam int STATUS_FAIL_BIT = 0;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int BUSY_START_NS = 100;
  localparam int BUSY_START_CYC_RAW = (BUSY_START_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BUSY_START_CYC =
    4'((BUSY_START_CYC_RAW < 1) ? 1 : BUSY_START_CYC_RAW);

endpackage

// file: src/nand_read_fifo.sv
// Synchronous FIFO holding bytes read out of the flash
`timescale 1ns/1ps
`default_nettype none
module nand_read_fifo
  #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
  )
  (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
  );

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // ==========================================================
  // Storage
  always_ff @(posedge mclk)
  begin
    if (ce && push)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

  // ==========================================================
  // Pointers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop)
      begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/nand_dev_model.sv
// Behavioural flash device on the host's pins
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model
  #(
    parameter int BUSY = 20
  )
  (
    input wire logic mclk,
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic [7:0] dqOut,
    input wire logic fail,
    output logic [7:0] dqIn,
    output logic rbReady
  );
  logic [7:0] mem [0:4095];
  logic [11:0] col;
  logic [2:0] na;
  logic stMode, kick, seen, rPrev;
  int cnt, nSetup;
  // ==========================================================
  // Array and busy
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5A;
    {col, na, stMode, kick, seen, cnt, nSetup, dqIn} = '0;
    rPrev = 1'b1;
  end
  // Combinational so the host sees busy at once
  assign rbReady = (cnt == 0) && (kick == seen);
  always @(posedge mclk)
  begin
    if (kick != seen)
    begin
      seen <= kick;
      cnt <= BUSY;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Released lines show the inverse, not a held value
  always @(posedge weN or reN)
  begin
    if (reN !== rPrev)
    begin
      rPrev = reN;
      if (!reN && !ceN)
      begin
        dqIn <= stMode ? {2'b11, rbReady, 4'h0, fail} : mem[col];
        col <= stMode ? col : col + 12'h1;
      end
      else
        dqIn <= ~dqIn;
    end
    else if (!ceN && cle && (rbReady || dqOut inside {8'h70, 8'hFF, 8'h34}))
    begin
      stMode <= dqOut == 8'h70;
      na <= 3'h0;
      nSetup <= nSetup + int'(dqOut == 8'h00);
      if (dqOut inside {8'h30, 8'h31, 8'h35, 8'h10})
        kick <= ~kick;
    end
    else if (!ceN && ale)
    begin
      na <= na + 3'h1;
      if (na == 3'h0)
        col[7:0] <= dqOut;
      if (na == 3'h1)
        col[11:8] <= dqOut[3:0];
    end
    else if (!ceN && !cle)
    begin
      mem[col] <= dqOut;
      col <= col + 12'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/nand_host_assertions.sv
// Checker of the flash host sequencer's ports
`timescale 1ns/1ps
`default_nettype none
module nand_host_chk
  import nand_host_pkg::*;
  (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire op_t cmdOp,
    input wire logic [LEN_W-1:0] cmdLen,
    input wire logic cmdReady,
    input wire logic cmdDone,
    input wire logic cmdErr,
    input wire logic [DATA_W-1:0] statusByte,
    input wire logic opFail,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic dqOe,
    input wire logic rbReady
  );
  // ==========================================================
  // Properties
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |-> weN && reN && !dqOe)
    else $error("strobes active after reset");
  a_latch_excl: assert property (!(cle && ale))
    else $error("both latch enables high");
  a_we_pulse: assert property ($fell(weN) |=> $rose(weN))
    else $error("write strobe not one cycle");
  a_we_drive: assert property (!weN |-> dqOe && reN)
    else $error("write cycle without drive");
  a_re_release: assert property (!reN |-> !dqOe ##1 reN)
    else $error("read strobe misuse");
  a_read_ready: assert property ($fell(reN) |-> $past(rbReady))
    else $error("read while busy");
  a_len_refuse: assert property (cmdValid && cmdReady
    && cmdOp inside {OP_PROG_LOAD, OP_RAND_IN}
    && (cmdLen == 0 || cmdLen > PAGE_BYTES) |=> cmdErr)
    else $error("bad length taken");
  a_take_busy: assert property (cmdValid && cmdReady |=> !cmdReady)
    else $error("ready kept after take");
  a_err_pulse: assert property (cmdErr |-> !cmdDone ##1 !cmdErr)
    else $error("refusal not a pulse");
  a_op_ends: assert property ($fell(cmdReady)
    |-> ##[0:1000] (cmdDone || cmdErr))
    else $error("operation never ends");
  a_fail_bit: assert property ($rose(opFail)
    |-> statusByte[STATUS_FAIL_BIT])
    else $error("fail flag without status");
endmodule
bind nand_host nand_host_chk chk (.mclk(mclk), .rst(rst),
  .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdLen(cmdLen),
  .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdErr(cmdErr),
  .statusByte(statusByte), .opFail(opFail), .cle(cle), .ale(ale),
  .weN(weN), .reN(reN), .dqOe(dqOe), .rbReady(rbReady));
`default_nettype wire

// file: tb/nand_host_tb_top.sv
// Self-checking bench of the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_host_tb_top
  import nand_host_pkg::*;
  ;
  logic mclk, rst, cmdValid, cmdReady, cmdDone, cmdErr, wrValid, wrReady;
  logic rdValid, rdReady, opFail, ceN, cle, ale, weN, reN, dqOe, rbReady;
  logic fail;
  op_t cmdOp;
  logic [COL_W-1:0] cmdCol;
  logic [ROW_W-1:0] cmdRow;
  logic [LEN_W-1:0] cmdLen;
  logic [7:0] wrData, rdData, statusByte, dqOut, dqIn;
  logic [7:0] sh [0:4095];
  logic [7:0] wq[$];
  logic [7:0] eq[$];
  int miscompares, num_checks, n0, c;
  // ==========================================================
  // Harness
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  nand_host DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdCol(cmdCol), .cmdRow(cmdRow), .cmdLen(cmdLen),
    .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdErr(cmdErr),
    .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
    .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady),
    .statusByte(statusByte), .opFail(opFail), .ceN(ceN), .cle(cle),
    .ale(ale), .weN(weN), .reN(reN), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn), .rbReady(rbReady));
  nand_dev_model dev (.mclk(mclk), .ceN(ceN), .cle(cle), .ale(ale),
    .weN(weN), .reN(reN), .dqOut(dqOut), .fail(fail), .dqIn(dqIn),
    .rbReady(rbReady));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic run(op_t o, int cc, int r, int n, logic e);
    logic got;
    got = 1'bx;
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdOp <= o;
    cmdCol <= COL_W'(cc);
    cmdRow <= ROW_W'(r);
    cmdLen <= LEN_W'(n);
    do @(negedge mclk); while (cmdReady !== 1'b1);
    @(posedge mclk);
    cmdValid <= 1'b0;
    repeat (3000)
    begin
      @(negedge mclk);
      if (cmdDone === 1'b1 || cmdErr === 1'b1)
      begin
        got = cmdErr;
        break;
      end
    end
    chk({7'h0, got}, {7'h0, e});
  endtask
  task automatic rd(op_t o, int cc, int n);
    for (int i = 0; i < n; i++)
      eq.push_back(sh[cc + i]);
    run(o, cc, 5, n, 1'b0);
  endtask
  task automatic pg(op_t o, int cc, int r, int n);
    for (int i = 0; i < n; i++)
    begin
      wq.push_back(8'($urandom));
      sh[cc + i] = wq[$];
    end
    run(o, cc, r, n, 1'b0);
  endtask
  // Stalling reader; writer holds data until taken
  always @(posedge mclk)
  begin
    rdReady <= ($urandom % 4) != 0;
    if (rdValid === 1'b1 && rdReady)
      chk(rdData, eq.size() ? eq.pop_front() : 8'hXX);
    if (wrValid && wrReady)
      void'(wq.pop_front());
    wrValid <= wq.size() > 0;
    wrData <= wq.size() ? wq[0] : 8'h00;
  end
  // ==========================================================
  // Tests
  initial
  begin
    void'($urandom(32'h238EAF59));
    for (int i = 0; i < 4096; i++)
      sh[i] = 8'(i) ^ 8'h5A;
    {cmdValid, cmdCol, cmdRow, cmdLen, fail} = '0;
    cmdOp = OP_READ;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(OP_READ, 0, 4);
    n0 = dev.nSetup;
    rd(OP_READ, 100, 3);
    chk(8'(dev.nSetup), 8'(n0));
    rd(OP_RAND_OUT, 2000, 3);
    c = $urandom % 1000;
    pg(OP_PROG_LOAD, c, 9, 6);
    pg(OP_RAND_IN, c + 500, 9, 3);
    run(OP_PROG_GO, 0, 9, 0, 1'b0);
    chk(statusByte & 8'h41, 8'h40);
    run(OP_STATUS, 0, 9, 0, 1'b0);
    chk(statusByte & 8'h60, 8'h60);
    rd(OP_READ, c, 6);
    rd(OP_READ, c + 500, 3);
    run(OP_PROG_GO, 0, 9, 0, 1'b1);
    run(OP_PROG_LOAD, 0, 9, 0, 1'b1);
    run(OP_PROG_LOAD, 0, 9, 2113, 1'b1);
    fail <= 1'b1;
    pg(OP_PROG_LOAD, 50, 11, 1);
    run(OP_PROG_GO, 0, 11, 0, 1'b0);
    chk({7'h0, opFail}, 8'h01);
    fail <= 1'b0;
    rd(OP_CACHE_READ, 0, 4);
    run(OP_RAND_OUT, 10, 5, 2, 1'b1);
    run(OP_CACHE_EXIT, 0, 5, 0, 1'b0);
    run(OP_COPY_READ, 0, 2, 0, 1'b0);
    run(OP_COPY_PROG, 0, 3, 0, 1'b1);
    run(OP_COPY_PROG, 0, 32'h10002, 0, 1'b1);
    run(OP_COPY_PROG, 0, 4, 0, 1'b0);
    run(OP_RESET, 0, 0, 0, 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      pg(OP_PROG_LOAD, 200 + i, 7, 1);
      run(OP_PROG_GO, 0, 7, 0, i == 8);
    end
    repeat (200)
      if (eq.size())
        @(posedge mclk);
    chk(8'(eq.size()), 8'h00);
    stop_test();
  end
  // Whole run needs well under 10000 cycles
  initial
  begin
    #3000000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
